// ### rx_pkt_cfg_pkg.sv
// Shared constants and types for the receive packet configuration block
package rx_pkt_cfg_pkg;

    // Register addresses on the configuration port
    localparam logic [4:0] ADDR_SYNC_PARAM  = 5'h12; // sync_parameters
    localparam logic [4:0] ADDR_SYNC_BYTE3  = 5'h16; // Most significant pattern byte
    localparam logic [4:0] ADDR_SYNC_BYTE2  = 5'h17;
    localparam logic [4:0] ADDR_SYNC_BYTE1  = 5'h18;
    localparam logic [4:0] ADDR_SYNC_BYTE0  = 5'h19;
    localparam logic [4:0] ADDR_CLK_OUT     = 5'h1B; // clock_output_control
    localparam logic [4:0] ADDR_DEC_LEN     = 5'h1C; // decoding_and_length
    localparam logic [4:0] ADDR_NODE        = 5'h1D; // local_node_address
    localparam logic [4:0] ADDR_PKT_FMT     = 5'h1E; // packet_format_control
    localparam logic [4:0] ADDR_AUTOCLR     = 5'h1F; // fifo_autoclear_control

    // Reset values
    localparam logic [7:0] RST_SYNC_BYTE    = 8'h00;
    localparam logic [7:0] RST_SYNC_PARAM   = 8'h18; // Off, 32-bit size, no tolerance
    localparam logic [7:0] RST_CLK_OUT      = 8'hBC; // Enabled, divider 01111
    localparam logic [7:0] RST_DEC_LEN      = 8'h00;
    localparam logic [7:0] RST_NODE         = 8'h00;
    localparam logic [7:0] RST_PKT_FMT      = 8'h48; // Fixed, reserved 10, checksum on
    localparam logic [7:0] RST_AUTOCLR      = 8'h00;

    // Field positions
    localparam int BIT_SYNC_ON  = 5;
    localparam int SIZE_HI      = 4;
    localparam int SIZE_LO      = 3;
    localparam int TOL_HI       = 2;
    localparam int TOL_LO       = 1;
    localparam int BIT_CLKOUT   = 7;
    localparam int DIV_HI       = 6;
    localparam int DIV_LO       = 2;
    localparam int BIT_MANCH    = 7;
    localparam int LEN_HI       = 6;
    localparam int BIT_FORMAT   = 7;
    localparam int BIT_WHITE    = 4;
    localparam int BIT_CRC_ON   = 3;
    localparam int FILT_HI      = 2;
    localparam int FILT_LO      = 1;
    localparam int BIT_CRC_STAT = 0;
    localparam int BIT_AUTOCLR  = 7;

    // Address filter modes
    localparam logic [1:0] FILT_OFF  = 2'h0;
    localparam logic [1:0] FILT_NODE = 2'h1;
    localparam logic [1:0] FILT_ZERO = 2'h2;
    localparam logic [1:0] FILT_BOTH = 2'h3;
    localparam logic [7:0] BCAST_ZERO = 8'h00;
    localparam logic [7:0] BCAST_ONES = 8'hFF;

    // Configuration port framing: header byte then data byte, MSB first
    localparam int HDR_RW_BIT  = 6;  // 1 reads, 0 writes
    localparam int HDR_ADDR_HI = 5;
    localparam int HDR_ADDR_LO = 1;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] CNT_ZERO  = 4'h0;
    localparam logic [3:0] CNT_ONE   = 4'h1;
    localparam logic [4:0] DIV_ZERO  = 5'h00;
    localparam logic [4:0] DIV_ONE   = 5'h01;
    localparam logic [5:0] SYNC_MAX_BITS = 6'h20;
    localparam logic [5:0] BITS_PER_BYTE = 6'h08;

    // Sync detector configuration carried as one bundle
    typedef struct packed {
        logic        on;
        logic [1:0]  size;
        logic [1:0]  tol;
        logic [31:0] pattern;
    } sync_cfg_type;

    // Configuration port transaction state
    typedef enum logic [1:0] {SPI_IDLE, SPI_HEAD, SPI_DATA, SPI_DONE} spi_state_type;

endpackage

// ### sync_word_matcher.sv
// Sync word detector with size selection and bit error tolerance
`timescale 1ns/1ps
module sync_word_matcher
    import rx_pkt_cfg_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rstn,
    input  wire rx_pkt_cfg_pkg::sync_cfg_type cfg,
    input  wire logic                         bit_valid,
    input  wire logic                         bit_in,
    output logic                              found
);
    import rx_pkt_cfg_pkg::*;

    logic [31:0] shift_reg, shift_next;  // Last 32 received bits
    logic [5:0]  cnt_reg, cnt_next;      // Bits seen, saturating
    logic        found_reg, found_next;  // One-cycle detection pulse
    logic [5:0]  err_count;              // Mismatches in the window

    // Bits compared for a size code
    function automatic logic [5:0] size_bits(input logic [1:0] size);
        size_bits = (6'({4'h0, size}) + 6'h01) * BITS_PER_BYTE;
    endfunction

    // Ones in a word
    function automatic logic [5:0] pop_count(input logic [31:0] v);
        pop_count = 6'h00;
        for (int i = 0; i < 32; i++)
            pop_count = pop_count + 6'({5'h00, v[i]});
    endfunction

    // Pattern's leading bytes aligned to the newest bits, masked to size
    always_comb
    begin
        logic [31:0] mask;
        logic [31:0] aligned;
        mask    = 32'hFFFF_FFFF >> (SYNC_MAX_BITS - size_bits(cfg.size)); // RQ2
        aligned = cfg.pattern >> (SYNC_MAX_BITS - size_bits(cfg.size));  // RQ2
        err_count = pop_count((shift_next ^ aligned) & mask);
    end

    // Shift and compare on every received bit while sync is on
    always_comb
    begin
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        found_next = 1'b0;
        if (!cfg.on)
        begin
            cnt_next = 6'h00;  // RQ14
        end
        else if (bit_valid)
        begin
            shift_next = {shift_reg[30:0], bit_in};
            if (cnt_reg != SYNC_MAX_BITS)
                cnt_next = cnt_reg + 6'h01;
            // Window must be full so stale zeros cannot match
            found_next = (cnt_next >= size_bits(cfg.size))
                         && (err_count <= 6'({4'h0, cfg.tol})); // RQ13
        end
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            shift_reg <= 32'h0000_0000;
            cnt_reg   <= 6'h00;
            found_reg <= 1'b0;
        end
        else
        begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            found_reg <= found_next;
        end
    end

    assign found = found_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_sync_disabled: assert property (!cfg.on |=> !found) // RQ14
        else $error("sync found while disabled");
    a_sync_tolerance: assert property (found_next |-> err_count <= 6'({4'h0, cfg.tol})) // RQ13
        else $error("sync found with too many errors");
    a_sync_window: assert property (found |-> $past(cnt_next) >= size_bits($past(cfg.size))) // RQ2
        else $error("sync found before window full");
    c_sync_found: cover property (cfg.on && found);
endmodule

// ### rx_packet_handler_config.sv
// Receive packet handler configuration registers, clock output and checks
// Contract
// [RQ1] Four sync bytes at 22-25, MSB first
// [RQ2] Compare only bytes selected by sync size
// [RQ3] Bit 7 of 27 gates clock output
// [RQ4] Divider zero passes crystal, else divides 2N
// [RQ5] Length field: exact or maximum payload length
// [RQ6] Local node address at 29 for filtering
// [RQ7] Bit 7 of 30 selects fixed/variable format
// [RQ8] Filter modes accept node, zero, all-ones
// [RQ9] Checksum pass/fail readable in bit 0
// [RQ10] Auto-clear FIFO on checksum fail unless disabled
// [RQ11] Host writes reserved bits of 31 as 1000000
// [RQ12] Manchester and dewhitening enables, off at reset
// [RQ13] Sync tolerates zero to three bit errors
// [RQ14] Sync recognition only when enabled
`timescale 1ns/1ps
module rx_packet_handler_config
    import rx_pkt_cfg_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic       SPI_SCK,
    input  wire logic       SPI_NSS_N,
    input  wire logic       SPI_MOSI,
    output logic            SPI_MISO,
    output logic            SPI_MISO_OE,
    input  wire logic       RX_BIT_VALID,
    input  wire logic       RX_BIT,
    output logic            SYNC_FOUND,
    input  wire logic       ADDR_VALID,
    input  wire logic [7:0] ADDR_BYTE,
    output logic            ADDR_ACCEPT,
    output logic            ADDR_REJECT,
    input  wire logic       CRC_DONE,
    input  wire logic       CRC_OK,
    output logic            FIFO_CLEAR,
    output logic            CLKOUT,
    output logic            MANCHESTER_EN,
    output logic            DEWHITEN_EN,
    output logic            PKT_VARIABLE,
    output logic            CRC_CHECK_EN,
    output logic [6:0]      PAYLOAD_LENGTH
);
    import rx_pkt_cfg_pkg::*;

    // Configuration port state
    spi_state_type state_reg, state_next;   // Transaction phase
    logic          sck_prev_reg;            // Last SCK sample for edges
    logic [3:0]    bit_cnt_reg, bit_cnt_next;
    logic [7:0]    shin_reg, shin_next;     // Incoming bits
    logic [7:0]    shout_reg, shout_next;   // Outgoing read data
    logic [4:0]    addr_reg, addr_next;     // Latched register address
    logic          read_reg, read_next;     // Latched direction
    logic          wr_en;                   // One-cycle write commit
    logic [7:0]    wr_data;
    logic          sck_rise, sck_fall;

    // Register file
    logic [7:0] sync_param_reg, sync_param_next;
    logic [7:0] sync_b3_reg, sync_b3_next;
    logic [7:0] sync_b2_reg, sync_b2_next;
    logic [7:0] sync_b1_reg, sync_b1_next;
    logic [7:0] sync_b0_reg, sync_b0_next;
    logic [7:0] clk_out_reg, clk_out_next;
    logic [7:0] dec_len_reg, dec_len_next;
    logic [7:0] node_reg, node_next;
    logic [7:0] pkt_fmt_reg, pkt_fmt_next;  // Bit 0 is hardware status
    logic [7:0] autoclr_reg, autoclr_next;

    // Packet check outputs
    logic accept_reg, accept_next;
    logic reject_reg, reject_next;
    logic clear_reg, clear_next;

    // Clock output divider
    logic [4:0] div_cnt_reg, div_cnt_next;
    logic       div_clk_reg, div_clk_next;
    logic [4:0] div_value;

    sync_cfg_type sync_cfg;

    // Register read decode; unmapped addresses read zero
    function automatic logic [7:0] reg_read(input logic [4:0] a);
        unique case (a)
            ADDR_SYNC_PARAM: reg_read = sync_param_reg;
            ADDR_SYNC_BYTE3: reg_read = sync_b3_reg;
            ADDR_SYNC_BYTE2: reg_read = sync_b2_reg;
            ADDR_SYNC_BYTE1: reg_read = sync_b1_reg;
            ADDR_SYNC_BYTE0: reg_read = sync_b0_reg;
            ADDR_CLK_OUT:    reg_read = clk_out_reg;
            ADDR_DEC_LEN:    reg_read = dec_len_reg;
            ADDR_NODE:       reg_read = node_reg;
            ADDR_PKT_FMT:    reg_read = pkt_fmt_reg;
            ADDR_AUTOCLR:    reg_read = autoclr_reg;
            default:         reg_read = 8'h00;
        endcase
    endfunction

    // Address filter decision
    function automatic logic addr_ok(input logic [7:0] b, input logic [7:0] node,
                                     input logic [1:0] mode);
        unique case (mode)
            FILT_OFF:  addr_ok = 1'b1;
            FILT_NODE: addr_ok = (b == node);
            FILT_ZERO: addr_ok = (b == node) || (b == BCAST_ZERO);
            FILT_BOTH: addr_ok = (b == node) || (b == BCAST_ZERO) || (b == BCAST_ONES);
        endcase
    endfunction

    assign sck_rise = SPI_SCK && !sck_prev_reg;
    assign sck_fall = !SPI_SCK && sck_prev_reg;

    // Port sequencer: header byte, then data byte
    always_comb
    begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shin_next    = shin_reg;
        shout_next   = shout_reg;
        addr_next    = addr_reg;
        read_next    = read_reg;
        wr_en        = 1'b0;
        wr_data      = {shin_reg[6:0], SPI_MOSI};
        if (SPI_NSS_N)
        begin
            // Deselect aborts any partial transaction
            state_next   = SPI_IDLE;
            bit_cnt_next = CNT_ZERO;
        end
        else
        begin
            unique case (state_reg)
                SPI_IDLE:
                begin
                    state_next   = SPI_HEAD;
                    bit_cnt_next = CNT_ZERO;
                end
                SPI_HEAD:
                    if (sck_rise)
                    begin
                        shin_next    = wr_data;
                        bit_cnt_next = bit_cnt_reg + CNT_ONE;
                        if (bit_cnt_reg == BYTE_LAST)
                        begin
                            addr_next    = wr_data[HDR_ADDR_HI:HDR_ADDR_LO];
                            read_next    = wr_data[HDR_RW_BIT];
                            shout_next   = reg_read(wr_data[HDR_ADDR_HI:HDR_ADDR_LO]);
                            bit_cnt_next = CNT_ZERO;
                            state_next   = SPI_DATA;
                        end
                    end
                SPI_DATA:
                begin
                    // Shift after the first data bit was taken
                    if (sck_fall && bit_cnt_reg != CNT_ZERO)
                        shout_next = {shout_reg[6:0], 1'b0};
                    if (sck_rise)
                    begin
                        shin_next    = wr_data;
                        bit_cnt_next = bit_cnt_reg + CNT_ONE;
                        if (bit_cnt_reg == BYTE_LAST)
                        begin
                            wr_en      = !read_reg;
                            state_next = SPI_DONE;
                        end
                    end
                end
                SPI_DONE:
                    state_next = SPI_DONE;
            endcase
        end
    end

    // Register writes and hardware status
    always_comb
    begin
        sync_param_next = sync_param_reg;
        sync_b3_next    = sync_b3_reg;
        sync_b2_next    = sync_b2_reg;
        sync_b1_next    = sync_b1_reg;
        sync_b0_next    = sync_b0_reg;
        clk_out_next    = clk_out_reg;
        dec_len_next    = dec_len_reg;
        node_next       = node_reg;
        pkt_fmt_next    = pkt_fmt_reg;
        autoclr_next    = autoclr_reg;
        if (wr_en)
        begin
            unique case (addr_reg)
                ADDR_SYNC_PARAM: sync_param_next = wr_data;
                ADDR_SYNC_BYTE3: sync_b3_next    = wr_data; // RQ1
                ADDR_SYNC_BYTE2: sync_b2_next    = wr_data; // RQ1
                ADDR_SYNC_BYTE1: sync_b1_next    = wr_data; // RQ1
                ADDR_SYNC_BYTE0: sync_b0_next    = wr_data; // RQ1
                ADDR_CLK_OUT:    clk_out_next    = wr_data; // RQ3
                ADDR_DEC_LEN:    dec_len_next    = wr_data; // RQ5
                ADDR_NODE:       node_next       = wr_data; // RQ6
                // Status bit is read-only; writes keep it
                ADDR_PKT_FMT:    pkt_fmt_next    = {wr_data[7:1], pkt_fmt_reg[BIT_CRC_STAT]};
                ADDR_AUTOCLR:    autoclr_next    = wr_data; // RQ10
                default:         ;
            endcase
        end
        // Hardware result overrides a same-cycle write of the register
        if (CRC_DONE && pkt_fmt_reg[BIT_CRC_ON])
            pkt_fmt_next[BIT_CRC_STAT] = CRC_OK; // RQ9
    end

    // Address filter and checksum actions
    always_comb
    begin
        accept_next = 1'b0;
        reject_next = 1'b0;
        clear_next  = 1'b0;
        if (ADDR_VALID)
        begin
            accept_next = addr_ok(ADDR_BYTE, node_reg, pkt_fmt_reg[FILT_HI:FILT_LO]); // RQ8
            reject_next = !accept_next; // RQ6
        end
        // Auto-clear bit is active low: zero enables clearing
        if (CRC_DONE && pkt_fmt_reg[BIT_CRC_ON] && !CRC_OK && !autoclr_reg[BIT_AUTOCLR])
            clear_next = 1'b1; // RQ10
    end

    // Divider toggles every N cycles for crystal/(2N)
    assign div_value = clk_out_reg[DIV_HI:DIV_LO];
    always_comb
    begin
        div_cnt_next = div_cnt_reg;
        div_clk_next = div_clk_reg;
        if (!clk_out_reg[BIT_CLKOUT] || div_value == DIV_ZERO)
        begin
            div_cnt_next = DIV_ZERO;
            div_clk_next = 1'b0;
        end
        else if (div_cnt_reg >= div_value - DIV_ONE)
        begin
            div_cnt_next = DIV_ZERO;
            div_clk_next = !div_clk_reg; // RQ4
        end
        else
            div_cnt_next = div_cnt_reg + DIV_ONE;
    end

    // All state registers
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            state_reg      <= SPI_IDLE;
            sck_prev_reg   <= 1'b0;
            bit_cnt_reg    <= CNT_ZERO;
            shin_reg       <= 8'h00;
            shout_reg      <= 8'h00;
            addr_reg       <= 5'h00;
            read_reg       <= 1'b0;
            sync_param_reg <= RST_SYNC_PARAM;
            sync_b3_reg    <= RST_SYNC_BYTE;
            sync_b2_reg    <= RST_SYNC_BYTE;
            sync_b1_reg    <= RST_SYNC_BYTE;
            sync_b0_reg    <= RST_SYNC_BYTE;
            clk_out_reg    <= RST_CLK_OUT;
            dec_len_reg    <= RST_DEC_LEN;
            node_reg       <= RST_NODE;
            pkt_fmt_reg    <= RST_PKT_FMT;
            autoclr_reg    <= RST_AUTOCLR;
            accept_reg     <= 1'b0;
            reject_reg     <= 1'b0;
            clear_reg      <= 1'b0;
            div_cnt_reg    <= DIV_ZERO;
            div_clk_reg    <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            sck_prev_reg   <= SPI_SCK;
            bit_cnt_reg    <= bit_cnt_next;
            shin_reg       <= shin_next;
            shout_reg      <= shout_next;
            addr_reg       <= addr_next;
            read_reg       <= read_next;
            sync_param_reg <= sync_param_next;
            sync_b3_reg    <= sync_b3_next;
            sync_b2_reg    <= sync_b2_next;
            sync_b1_reg    <= sync_b1_next;
            sync_b0_reg    <= sync_b0_next;
            clk_out_reg    <= clk_out_next;
            dec_len_reg    <= dec_len_next;
            node_reg       <= node_next;
            pkt_fmt_reg    <= pkt_fmt_next;
            autoclr_reg    <= autoclr_next;
            accept_reg     <= accept_next;
            reject_reg     <= reject_next;
            clear_reg      <= clear_next;
            div_cnt_reg    <= div_cnt_next;
            div_clk_reg    <= div_clk_next;
        end
    end

    // Sync detector configuration, first byte most significant
    assign sync_cfg = '{on:      sync_param_reg[BIT_SYNC_ON],
                        size:    sync_param_reg[SIZE_HI:SIZE_LO],
                        tol:     sync_param_reg[TOL_HI:TOL_LO],
                        pattern: {sync_b3_reg, sync_b2_reg, sync_b1_reg, sync_b0_reg}}; // RQ1

    sync_word_matcher u_sync (
        .clk       (CLK),
        .rstn      (RSTN),
        .cfg       (sync_cfg),
        .bit_valid (RX_BIT_VALID),
        .bit_in    (RX_BIT),
        .found     (SYNC_FOUND)
    );

    // Undivided setting forwards the crystal clock itself, gated by enable
    assign CLKOUT = clk_out_reg[BIT_CLKOUT]
                    && ((div_value == DIV_ZERO) ? CLK : div_clk_reg); // RQ3
    assign SPI_MISO       = shout_reg[7];
    assign SPI_MISO_OE    = (state_reg == SPI_DATA) && read_reg;
    assign ADDR_ACCEPT    = accept_reg;
    assign ADDR_REJECT    = reject_reg;
    assign FIFO_CLEAR     = clear_reg;
    assign MANCHESTER_EN  = dec_len_reg[BIT_MANCH];   // RQ12
    assign DEWHITEN_EN    = pkt_fmt_reg[BIT_WHITE];   // RQ12
    assign PKT_VARIABLE   = pkt_fmt_reg[BIT_FORMAT];  // RQ7
    assign CRC_CHECK_EN   = pkt_fmt_reg[BIT_CRC_ON];
    assign PAYLOAD_LENGTH = dec_len_reg[LEN_HI:0];    // RQ5

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    a_pattern_write: assert property (wr_en && addr_reg == ADDR_SYNC_BYTE3
                                      |=> sync_cfg.pattern[31:24] == $past(wr_data)) // RQ1
        else $error("sync byte 3 not stored");
    a_clkout_gate: assert property (!clk_out_reg[BIT_CLKOUT] |-> !CLKOUT) // RQ3
        else $error("clock output active while disabled");
    a_divider_toggle: assert property (div_value != DIV_ZERO && $stable(clk_out_reg)
                                       && clk_out_reg == $past(clk_out_reg, 2)
                                       && div_clk_reg != $past(div_clk_reg)
                                       |-> $past(div_cnt_reg) == div_value - DIV_ONE) // RQ4
        else $error("divider toggled at wrong count");
    a_node_filter: assert property (ADDR_VALID && pkt_fmt_reg[FILT_HI:FILT_LO] == FILT_NODE
                                    && ADDR_BYTE != node_reg |=> ADDR_REJECT && !ADDR_ACCEPT) // RQ6
        else $error("foreign address not rejected");
    a_filter_off: assert property (ADDR_VALID && pkt_fmt_reg[FILT_HI:FILT_LO] == FILT_OFF
                                   |=> ADDR_ACCEPT) // RQ8
        else $error("filter off rejected a packet");
    a_ones_broadcast: assert property (ADDR_VALID && ADDR_BYTE == BCAST_ONES && ADDR_BYTE != node_reg
                                       && pkt_fmt_reg[FILT_HI:FILT_LO] == FILT_ZERO |=> ADDR_REJECT) // RQ8
        else $error("all-ones accepted in zero-only mode");
    a_crc_status: assert property (CRC_DONE && pkt_fmt_reg[BIT_CRC_ON]
                                   |=> pkt_fmt_reg[BIT_CRC_STAT] == $past(CRC_OK)) // RQ9
        else $error("checksum status not updated");
    a_auto_clear: assert property (CRC_DONE && !CRC_OK && pkt_fmt_reg[BIT_CRC_ON]
                                   |=> FIFO_CLEAR == !$past(autoclr_reg[BIT_AUTOCLR])) // RQ10
        else $error("fifo clear wrong on checksum fail");
    a_format_length: assert property (wr_en && addr_reg == ADDR_DEC_LEN
                                      |=> PAYLOAD_LENGTH == $past(wr_data[LEN_HI:0])) // RQ5
        else $error("payload length not applied");

    c_reg_write: cover property (wr_en);
    c_reg_read: cover property (SPI_MISO_OE ##1 state_reg == SPI_DONE);
    c_fifo_clear: cover property (FIFO_CLEAR);
    c_addr_accept: cover property (ADDR_ACCEPT && pkt_fmt_reg[FILT_HI:FILT_LO] == FILT_BOTH);
endmodule

// ### host_spi_model.sv
// Host controller model for the configuration port
`timescale 1ns/1ps
module host_spi_model (
    input  wire logic       clk,
    output logic            sck,
    output logic            nss_n,
    output logic            mosi,
    input  wire logic       miso,
    input  wire logic       miso_oe,
    output logic [7:0]      rd_data,
    output logic            rd_done
);
    initial {sck, nss_n, mosi, rd_done, rd_data} = 12'h400;
    // One frame; read bits taken before each rise, unknown if not driven
    task xfer(input logic rd, input logic [4:0] a, input logic [7:0] d);
        logic [15:0] f;
        begin
            f = {1'b0, rd, a, 1'b0, d};
            @(negedge clk) nss_n = 1'b0;
            repeat (2) @(negedge clk);
            for (int i = 15; i >= 0; i--)
            begin
                mosi = f[i];
                repeat (2) @(negedge clk);
                if (i < 8) rd_data[i] = miso_oe ? miso : 1'bx;
                sck = 1'b1;
                repeat (2) @(negedge clk);
                sck = 1'b0;
            end
            repeat (2) @(negedge clk);
            nss_n = 1'b1;
            mosi = ~mosi; // Released line shows no stale data
            rd_done = rd;
            @(negedge clk) rd_done = 1'b0;
        end
    endtask
endmodule

// ### rx_packet_handler_config_tb_top.sv
// Self-checking bench for the receive packet configuration block
`timescale 1ns/1ps
module rx_packet_handler_config_tb_top;
    import rx_pkt_cfg_pkg::*;
    logic CLK, RSTN, SPI_SCK, SPI_NSS_N, SPI_MOSI, SPI_MISO, SPI_MISO_OE, SYNC_FOUND;
    logic ADDR_VALID, CRC_DONE, CRC_OK, ADDR_ACCEPT, ADDR_REJECT, FIFO_CLEAR, CLKOUT;
    logic MANCHESTER_EN, DEWHITEN_EN, PKT_VARIABLE, CRC_CHECK_EN, rd_done, due, due_d;
    logic [7:0]  ADDR_BYTE, rd_data, hi;
    logic [6:0]  PAYLOAD_LENGTH;
    logic [15:0] rnd;
    logic [7:0]  rq[$];   // Expected read data
    logic [3:0]  eq[$];   // Expected found, accept, reject, clear
    int          fails, checked;
    logic        RX_BIT_VALID, RX_BIT;
    localparam logic [15:0] SYNC_BITS = 16'hA5A4; // Exact word, then one bit off
    rx_packet_handler_config dut_u (.CLK, .RSTN, .SPI_SCK, .SPI_NSS_N, .SPI_MOSI,
        .SPI_MISO, .SPI_MISO_OE, .RX_BIT_VALID, .RX_BIT, .SYNC_FOUND,
        .ADDR_VALID, .ADDR_BYTE, .ADDR_ACCEPT, .ADDR_REJECT, .CRC_DONE, .CRC_OK,
        .FIFO_CLEAR, .CLKOUT, .MANCHESTER_EN, .DEWHITEN_EN, .PKT_VARIABLE,
        .CRC_CHECK_EN, .PAYLOAD_LENGTH);
    host_spi_model host_u (.clk(CLK), .sck(SPI_SCK), .nss_n(SPI_NSS_N), .mosi(SPI_MOSI),
        .miso(SPI_MISO), .miso_oe(SPI_MISO_OE), .rd_data, .rd_done);
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        rq.push_back(e);
        host_u.xfer(1'b1, a, 8'h00);
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        host_u.xfer(1'b0, a, d);
    endtask
    // One packet event; its registered answer is due two edges on
    task pkt(input logic av, input logic [7:0] ab, input logic cd, ok, input logic [2:0] e);
        @(negedge CLK);
        {ADDR_VALID, ADDR_BYTE, CRC_DONE, CRC_OK, due} = {av, ab, cd, ok, 1'b1};
        eq.push_back({1'b0, e});
        @(negedge CLK);
        {ADDR_VALID, CRC_DONE, due} = 3'b000;
    endtask
    // One received bit; its detection pulse is due two edges on
    task sb(input logic b, input logic f);
        @(negedge CLK);
        {RX_BIT_VALID, RX_BIT, due} = {1'b1, b, 1'b1};
        eq.push_back({f, 3'b000});
        @(negedge CLK);
        {RX_BIT_VALID, due} = 2'b00;
    endtask
    // Clock output period in CLK cycles
    task per(input logic [7:0] e);
        time t0;
        repeat (2) @(posedge CLKOUT);
        t0 = $time;
        @(posedge CLKOUT);
        chk(8'(($time - t0) / 4), e);
    endtask
    // Watcher pairs each result with the oldest note
    always @(posedge CLK)
    begin
        due_d <= due;
        if (due_d) chk({4'h0, SYNC_FOUND, ADDR_ACCEPT, ADDR_REJECT, FIFO_CLEAR},
                       {4'h0, eq.pop_front()});
        if (rd_done) chk(rd_data, rq.pop_front());
    end
    task tally_and_finish;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #100000 fails++;
        tally_and_finish;
    end
    initial
    begin
        logic [4:0] ra[9] = '{5'h12, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
        logic [7:0] rv[9] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hBC, 8'h00, 8'h00};
        logic [4:0] wa[6] = '{5'h16, 5'h17, 5'h18, 5'h19, 5'h1D, 5'h1C};
        logic [7:0] bt[4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
        logic acc;
        {RSTN, RX_BIT_VALID, RX_BIT, ADDR_VALID, ADDR_BYTE, CRC_DONE, CRC_OK, due, due_d} = 16'h0000;
        {rnd, fails, checked} = {16'hE2C0, 32'h0000_0000, 32'h0000_0000};
        repeat (3) @(negedge CLK);
        RSTN = 1'b1;
        per(8'h1E);
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(ADDR_PKT_FMT, 8'h48);
        rd(ADDR_AUTOCLR, 8'h00);
        foreach (wa[i])
        begin
            rnd = lfsr(rnd);
            wr(wa[i], rnd[7:0]);
            rd(wa[i], rnd[7:0]);
        end
        chk({MANCHESTER_EN, PAYLOAD_LENGTH}, rnd[7:0]);
        wr(ADDR_SYNC_BYTE3, 8'hA5);
        wr(ADDR_SYNC_PARAM, 8'h20);
        for (int i = 15; i >= 0; i--) sb(SYNC_BITS[i], i == 8);
        wr(ADDR_NODE, 8'h5A);
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_PKT_FMT, {5'b11011, 2'(m), 1'b0});
            foreach (bt[i])
            begin
                acc = m == 0 || bt[i] == 8'h5A || (m > 1 && bt[i] == 8'h00) || (m == 3 && bt[i] == 8'hFF);
                pkt(1'b1, bt[i], 1'b0, 1'b0, {acc, ~acc, 1'b0});
            end
        end
        chk({6'h00, PKT_VARIABLE, DEWHITEN_EN}, 8'h03);
        pkt(1'b0, 8'h00, 1'b1, 1'b0, 3'b001);
        rd(ADDR_PKT_FMT, 8'hDE);
        pkt(1'b0, 8'h00, 1'b1, 1'b1, 3'b000);
        rd(ADDR_PKT_FMT, 8'hDF);
        wr(ADDR_AUTOCLR, 8'hC0);
        pkt(1'b0, 8'h00, 1'b1, 1'b0, 3'b000);
        pkt(1'b0, 8'h00, 1'b1, 1'b1, 3'b000);
        rd(ADDR_AUTOCLR, 8'hC0);
        wr(ADDR_AUTOCLR, 8'h40);
        wr(ADDR_PKT_FMT, 8'hD6);
        pkt(1'b0, 8'h00, 1'b1, 1'b0, 3'b000);
        rd(ADDR_PKT_FMT, 8'hD7);
        chk({7'h00, CRC_CHECK_EN}, 8'h00);
        wr(ADDR_CLK_OUT, 8'h84);
        per(8'h02);
        wr(ADDR_CLK_OUT, 8'h80);
        per(8'h01);
        wr(ADDR_CLK_OUT, 8'h3C);
        hi = 8'h00;
        repeat (40) @(negedge CLK) hi |= {7'h00, CLKOUT};
        chk(hi, 8'h00);
        tally_and_finish;
    end
endmodule
